// ==== design/tpa_aux_logic.sv ====
// Purpose: Guard-loss unblocking, current reversal, open-breaker keying, echo and weak-infeed trip
// Assumes: Pins are asynchronous and pass two flops; voltages come from same-clock logic
// Notes:   All delays are tick counters; a zero setting acts in the cycle its start is seen
`timescale 1ns/1ps
`default_nettype none
module tpa_aux_logic #(
   parameter int TICK_CYCLES = tpa_pkg::TICK_CYCLES
) (
   input  wire logic                  core_clk,
   input  wire logic                  rst_b,
   input  wire tpa_pkg::tpa_bus_req_t bus_req,
   output logic [31:0]                rd_data,
   input  wire logic                  guard_in_one,
   input  wire logic                  guard_in_two,
   input  wire logic                  reverse_zone_pickup,
   input  wire logic                  forward_zone_pickup,
   input  wire logic                  breaker_one_pos,
   input  wire logic                  breaker_two_pos,
   input  wire logic                  general_pickup_in,
   input  wire logic                  permissive_rx_one,
   input  wire logic                  permissive_rx_two,
   input  wire tpa_pkg::tpa_volt_t    phase_volt,
   output logic                       unblock_release,
   output logic                       unblock_trip,
   output logic                       chan_one_failed,
   output logic                       chan_two_failed,
   output logic                       reversal_block,
   output logic                       permissive_tx_out,
   output logic                       permissive_tx_ph_a,
   output logic                       permissive_tx_ph_b,
   output logic                       permissive_tx_ph_c,
   output logic                       echo_out,
   output logic                       weak_infeed_operated,
   output logic                       uv_pickup
);
   import tpa_pkg::*;

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   logic [8:0]  ctrl_q;
   logic [15:0] set_q [NUM_SETTINGS];
   logic [15:0] uv_thr_q;
   logic [15:0] uv_hyst_q;
   logic [31:0] status_w;

   function automatic logic is_setting(input logic [7:0] a);
      return (a >= OFS_SET0) && (a < OFS_UV_THR) && (a[1:0] == 2'b00);
   endfunction : is_setting

   function automatic int set_index(input logic [7:0] a);
      logic [7:0] rel;
      rel = a - OFS_SET0;
      return int'(rel[7:2]);
   endfunction : set_index

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q    <= CTRL_RST;
         uv_thr_q  <= UV_RST;
         uv_hyst_q <= UV_RST;
         for (int i = 0; i < NUM_SETTINGS; i++) begin
            set_q[i] <= SET_RST;
         end
      end else if (bus_req.wr) begin
         if (bus_req.addr == OFS_CTRL) begin
            ctrl_q <= bus_req.wdata[8:0];
         end else if (is_setting(bus_req.addr)) begin
            set_q[set_index(bus_req.addr)] <= bus_req.wdata[15:0];
         end else if (bus_req.addr == OFS_UV_THR) begin
            uv_thr_q <= bus_req.wdata[15:0];
         end else if (bus_req.addr == OFS_UV_HYST) begin
            uv_hyst_q <= bus_req.wdata[15:0];
         end
      end
   end

   // Read data stand for exactly the cycle after the strobe
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= 32'h0000_0000;
      end else if (!bus_req.rd) begin
         rd_data <= 32'h0000_0000;
      end else if (bus_req.addr == OFS_CTRL) begin
         rd_data <= {23'h000000, ctrl_q};
      end else if (is_setting(bus_req.addr)) begin
         rd_data <= {16'h0000, set_q[set_index(bus_req.addr)]};
      end else if (bus_req.addr == OFS_UV_THR) begin
         rd_data <= {16'h0000, uv_thr_q};
      end else if (bus_req.addr == OFS_UV_HYST) begin
         rd_data <= {16'h0000, uv_hyst_q};
      end else if (bus_req.addr == OFS_STATUS) begin
         rd_data <= status_w;
      end else begin
         rd_data <= 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [NUM_PINS-1:0] pin_raw;
   logic [NUM_PINS-1:0] pin_meta_q;
   logic [NUM_PINS-1:0] pin_q;

   assign pin_raw = {permissive_rx_two, permissive_rx_one, general_pickup_in, breaker_two_pos,
                     breaker_one_pos, forward_zone_pickup, reverse_zone_pickup, guard_in_two,
                     guard_in_one};

   generate
      for (genvar p = 0; p < NUM_PINS; p++) begin : g_sync
         always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
               pin_meta_q[p] <= 1'b0;
               pin_q[p]      <= 1'b0;
            end else begin
               pin_meta_q[p] <= pin_raw[p];
               pin_q[p]      <= pin_meta_q[p];
            end
         end
      end
   endgenerate

   logic guard_one_lost;
   logic guard_two_lost;
   logic guards_ok;
   logic bkr_open;
   logic rx_any;
   logic gen_pu;
   logic fwd_pu;

   assign guard_one_lost = ctrl_q[CB_GUARD1_EN] && !pin_q[PN_GUARD1];
   assign guard_two_lost = ctrl_q[CB_GUARD2_EN] && !pin_q[PN_GUARD2];
   assign guards_ok      = !guard_one_lost && !guard_two_lost;
   assign bkr_open       = !pin_q[PN_BKR1] && (!ctrl_q[CB_TWO_BKR] || !pin_q[PN_BKR2]);
   assign rx_any         = pin_q[PN_RX1] || pin_q[PN_RX2];
   assign gen_pu         = pin_q[PN_GENPU];
   assign fwd_pu         = pin_q[PN_FWD];

   // ------------------------------------------------------------
   // Timebase and delay timers
   // ------------------------------------------------------------
   // Long tick period is a parameter so simulation can shorten it
   logic [31:0] tick_cnt_q;
   logic        tick;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tick_cnt_q <= 32'h0000_0000;
      end else if (tick) begin
         tick_cnt_q <= 32'h0000_0000;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      end
   end
   assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));

   logic [NUM_TIMERS-1:0] t_cond;
   logic [NUM_TIMERS-1:0] t_exp;
   logic [15:0]           t_set [NUM_TIMERS];
   logic [15:0]           t_cnt_q [NUM_TIMERS];

   assign t_set[0]  = set_q[SI_GUARD_LOSS];
   assign t_set[1]  = set_q[SI_GUARD_LOSS];
   assign t_set[2]  = set_q[SI_CHAN_FAIL];
   assign t_set[3]  = set_q[SI_CHAN_FAIL];
   assign t_set[4]  = set_q[SI_WINDOW];
   assign t_set[5]  = set_q[SI_WINDOW];
   assign t_set[6]  = set_q[SI_REV_CONF];
   assign t_set[7]  = set_q[SI_REV_HOLD];
   assign t_set[8]  = set_q[SI_BKR_OPEN];
   assign t_set[9]  = set_q[SI_ECHO_CONF];
   assign t_set[10] = set_q[SI_ECHO_PULSE];
   assign t_set[11] = set_q[SI_ECHO_LOCK];
   assign t_set[12] = set_q[SI_PU_HOLD];
   assign t_set[13] = set_q[SI_WI_DELAY];

   generate
      for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_tmr
         always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
               t_cnt_q[t] <= 16'h0000;
            end else if (!t_cond[t]) begin
               t_cnt_q[t] <= 16'h0000;
            end else if (tick && (t_cnt_q[t] < t_set[t])) begin
               t_cnt_q[t] <= t_cnt_q[t] + 16'h0001;
            end
         end
         assign t_exp[t] = t_cond[t] && (t_cnt_q[t] >= t_set[t]);
      end
   endgenerate

   // ------------------------------------------------------------
   // Guard-loss unblocking and channel failure
   // ------------------------------------------------------------
   tpa_unblk_t ub_q;
   tpa_unblk_t ub_d;

   assign t_cond[0] = guard_one_lost;
   assign t_cond[1] = guard_two_lost;
   assign t_cond[2] = guard_one_lost;
   assign t_cond[3] = guard_two_lost;
   assign t_cond[4] = (ub_q == UB_RELEASE);
   assign t_cond[5] = (ub_q == UB_INOP) && guards_ok;

   always_comb begin
      ub_d = ub_q;
      case (ub_q)
         UB_QUIET: begin
            if (t_exp[0] || t_exp[1]) begin
               ub_d = UB_RELEASE;
            end
         end
         UB_RELEASE: begin
            if (t_exp[4]) begin
               ub_d = UB_INOP;
            end
         end
         UB_INOP: begin
            if (t_exp[5]) begin
               ub_d = UB_QUIET;
            end
         end
         default: ub_d = UB_QUIET;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ub_q            <= UB_QUIET;
         unblock_release <= 1'b0;
         unblock_trip    <= 1'b0;
         chan_one_failed <= 1'b0;
         chan_two_failed <= 1'b0;
      end else begin
         ub_q            <= ub_d;
         unblock_release <= (ub_d == UB_RELEASE);
         unblock_trip    <= (ub_d == UB_RELEASE) && fwd_pu;
         chan_one_failed <= t_exp[2];
         chan_two_failed <= t_exp[3];
      end
   end

   // ------------------------------------------------------------
   // Current reversal
   // ------------------------------------------------------------
   logic rev_pu;
   assign rev_pu    = ctrl_q[CB_REV_CONN] && pin_q[PN_REV];
   assign t_cond[6] = rev_pu;
   // Hold runs once the reverse decision has gone, letting the remote end reset
   assign t_cond[7] = reversal_block && !rev_pu;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         reversal_block <= 1'b0;
      end else if (t_exp[6]) begin
         reversal_block <= 1'b1;
      end else if (t_exp[7] || !ctrl_q[CB_REV_CONN]) begin
         reversal_block <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Undervoltage detector
   // ------------------------------------------------------------
   logic [31:0] thr_prod;
   logic [15:0] thr_pe;
   logic [16:0] thr_reset;
   logic        any_below;
   logic        all_above;

   assign thr_prod  = uv_thr_q * INV_SQRT3_Q16;
   assign thr_pe    = thr_prod[31:16];
   assign thr_reset = {1'b0, thr_pe} + {1'b0, uv_hyst_q};
   assign any_below = (phase_volt.ph_a < thr_pe) || (phase_volt.ph_b < thr_pe) ||
                      (phase_volt.ph_c < thr_pe);
   assign all_above = ({1'b0, phase_volt.ph_a} > thr_reset) && ({1'b0, phase_volt.ph_b} > thr_reset) &&
                      ({1'b0, phase_volt.ph_c} > thr_reset);

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         uv_pickup <= 1'b0;
      end else if (any_below) begin
         uv_pickup <= 1'b1;
      end else if (all_above) begin
         uv_pickup <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Echo transmission and pickup hold
   // ------------------------------------------------------------
   tpa_echo_t ec_q;
   tpa_echo_t ec_d;
   logic      pu_hold_q;
   logic      echo_ok;
   logic      echo_start;

   // Pickup hold keeps a late remote permission from producing a false echo
   assign t_cond[12] = pu_hold_q && !gen_pu;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pu_hold_q <= 1'b0;
      end else if (gen_pu) begin
         pu_hold_q <= 1'b1;
      end else if (t_exp[12]) begin
         pu_hold_q <= 1'b0;
      end
   end

   assign echo_ok    = ctrl_q[CB_ECHO_EN] && rx_any && !gen_pu && !pu_hold_q &&
                       (!ctrl_q[CB_ECHO_UV] || uv_pickup);
   assign t_cond[9]  = echo_ok && (ec_q == EC_IDLE);
   assign echo_start = t_exp[9] || (echo_ok && bkr_open);
   assign t_cond[10] = (ec_q == EC_PULSE);
   assign t_cond[11] = (ec_q == EC_LOCK);

   always_comb begin
      ec_d = ec_q;
      case (ec_q)
         EC_IDLE: begin
            if (echo_start) begin
               ec_d = EC_PULSE;
            end
         end
         EC_PULSE: begin
            if (t_exp[10]) begin
               ec_d = EC_LOCK;
            end
         end
         EC_LOCK: begin
            if (t_exp[11]) begin
               ec_d = EC_IDLE;
            end
         end
         default: ec_d = EC_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // Open-breaker keying and transmit outputs
   // ------------------------------------------------------------
   logic key_open;
   assign t_cond[8] = ctrl_q[CB_OPEN_KEY] && bkr_open;
   assign key_open  = t_exp[8];

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ec_q               <= EC_IDLE;
         echo_out           <= 1'b0;
         permissive_tx_out  <= 1'b0;
         permissive_tx_ph_a <= 1'b0;
         permissive_tx_ph_b <= 1'b0;
         permissive_tx_ph_c <= 1'b0;
      end else begin
         ec_q               <= ec_d;
         echo_out           <= (ec_d == EC_PULSE);
         permissive_tx_out  <= key_open || (ec_d == EC_PULSE);
         permissive_tx_ph_a <= ctrl_q[CB_PHASE_SEG] && (key_open || (ec_d == EC_PULSE));
         permissive_tx_ph_b <= ctrl_q[CB_PHASE_SEG] && (key_open || (ec_d == EC_PULSE));
         permissive_tx_ph_c <= ctrl_q[CB_PHASE_SEG] && (key_open || (ec_d == EC_PULSE));
      end
   end

   // ------------------------------------------------------------
   // Weak-infeed trip
   // ------------------------------------------------------------
   assign t_cond[13] = ctrl_q[CB_WI_EN] && rx_any && !gen_pu && !fwd_pu &&
                       !pu_hold_q && uv_pickup;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         weak_infeed_operated <= 1'b0;
      end else begin
         weak_infeed_operated <= t_exp[13];
      end
   end

   assign status_w = {20'h00000, ub_q, ec_q, uv_pickup, weak_infeed_operated, reversal_block,
                      chan_two_failed, chan_one_failed, pu_hold_q, key_open, unblock_trip};

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   a_release_cause: assert property ($rose(unblock_release) |-> $past(t_exp[0] || t_exp[1]))
      else $error("release opened without guard loss");
   a_window_end: assert property ((ub_q == UB_RELEASE) && t_exp[4] |=> !unblock_release)
      else $error("release outlived window");
   a_trip_window: assert property (unblock_trip |-> unblock_release && $past(fwd_pu))
      else $error("unblock trip outside window");
   a_inop_stay: assert property ((ub_q == UB_INOP) && !guards_ok |=> ub_q != UB_QUIET)
      else $error("quiescent without stable guard");
   a_chan_fail: assert property ($rose(chan_one_failed) |-> $past(guard_one_lost))
      else $error("channel fail without guard loss");
   a_rev_block: assert property ($rose(reversal_block) |-> $past(rev_pu && ctrl_q[CB_REV_CONN]))
      else $error("reversal block without reverse pickup");
   a_echo_gap: assert property ((ec_q == EC_LOCK) && !t_exp[11] |=> !echo_out && (ec_q == EC_LOCK))
      else $error("echo repeated without lockout");
   a_echo_uv: assert property ($rose(echo_out) && ctrl_q[CB_ECHO_UV] |-> $past(uv_pickup))
      else $error("echo sent without undervoltage");
   a_echo_pickup: assert property ($rose(echo_out) |-> $past(!gen_pu && !pu_hold_q))
      else $error("echo sent during pickup");
   a_wi_cause: assert property ($rose(weak_infeed_operated) |-> $past(uv_pickup && rx_any))
      else $error("weak infeed trip without cause");
endmodule : tpa_aux_logic
`default_nettype wire

// ==== design/tpa_pkg.sv ====
// Purpose: Shared constants and carrier types for the teleprotection auxiliary logic
// Assumes: 10 MHz core clock, 32-bit register port, settings counted in timebase ticks
// Notes:   Every offset, control and pin field position, register-file reset value and cycle count lives here
package tpa_pkg;
   // ------------------------------------------------------------
   // Clock and timebase
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int TICK_NS       = 1000000;
   localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int NUM_TIMERS    = 14;
   localparam int NUM_SETTINGS  = 11;
   localparam int NUM_PINS      = 9;

   // ------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_SET0    = 8'h04;
   localparam logic [7:0] OFS_UV_THR  = 8'h30;
   localparam logic [7:0] OFS_UV_HYST = 8'h34;
   localparam logic [7:0] OFS_STATUS  = 8'h38;

   // Setting indices, setting i at OFS_SET0 + 4*i
   localparam int SI_GUARD_LOSS = 0;
   localparam int SI_WINDOW     = 1;
   localparam int SI_CHAN_FAIL  = 2;
   localparam int SI_REV_CONF   = 3;
   localparam int SI_REV_HOLD   = 4;
   localparam int SI_BKR_OPEN   = 5;
   localparam int SI_ECHO_CONF  = 6;
   localparam int SI_ECHO_PULSE = 7;
   localparam int SI_ECHO_LOCK  = 8;
   localparam int SI_PU_HOLD    = 9;
   localparam int SI_WI_DELAY   = 10;

   // ------------------------------------------------------------
   // Control field positions and reset values
   // ------------------------------------------------------------
   localparam int CB_OPEN_KEY   = 0;
   localparam int CB_ECHO_UV    = 1;
   localparam int CB_ECHO_EN    = 2;
   localparam int CB_WI_EN      = 3;
   localparam int CB_REV_CONN   = 4;
   localparam int CB_PHASE_SEG  = 5;
   localparam int CB_TWO_BKR    = 6;
   localparam int CB_GUARD1_EN  = 7;
   localparam int CB_GUARD2_EN  = 8;
   localparam logic [8:0]  CTRL_RST = 9'h000;
   localparam logic [15:0] SET_RST  = 16'h0000;
   localparam logic [15:0] UV_RST   = 16'h0000;

   // 1/sqrt(3) in Q16
   localparam logic [15:0] INV_SQRT3_Q16 = 16'h93CD;

   // Pin positions in the synchronised vector
   localparam int PN_GUARD1 = 0;
   localparam int PN_GUARD2 = 1;
   localparam int PN_REV    = 2;
   localparam int PN_FWD    = 3;
   localparam int PN_BKR1   = 4;
   localparam int PN_BKR2   = 5;
   localparam int PN_GENPU  = 6;
   localparam int PN_RX1    = 7;
   localparam int PN_RX2    = 8;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } tpa_bus_req_t;

   typedef struct packed {
      logic [15:0] ph_a;
      logic [15:0] ph_b;
      logic [15:0] ph_c;
   } tpa_volt_t;

   typedef enum logic [1:0] {
      UB_QUIET   = 2'b00,
      UB_RELEASE = 2'b01,
      UB_INOP    = 2'b10
   } tpa_unblk_t;

   typedef enum logic [1:0] {
      EC_IDLE  = 2'b00,
      EC_PULSE = 2'b01,
      EC_LOCK  = 2'b10
   } tpa_echo_t;
endpackage : tpa_pkg

// ==== verification/teleprotection_aux_logic_tb.sv ====
// Purpose: Self-checking bench for the teleprotection auxiliary logic
// Assumes: Tick of 4 cycles; second channel and second breaker held, second guard left present
// Notes:   Free-running tick lets a delay land anywhere in one tick, so waits check ranges
`timescale 1ns/1ps
`default_nettype none
module teleprotection_aux_logic_tb;
   import tpa_pkg::*;
   localparam int TK = 4;
   logic         core_clk = 1'b0;
   logic         rst_b    = 1'b0;
   tpa_bus_req_t bus_req  = '0;
   logic [31:0]  rd_data;
   logic         key = 1'b0, guard_on = 1'b1, rev = 1'b0, fwd = 1'b0, bkr1 = 1'b1;
   logic         gpu = 1'b0, g2 = 1'b1;
   tpa_volt_t    volt = '0;
   logic         rx1, g1;
   wire logic [11:0] obs;
   int           num_errors = 0;
   int           checks = 0;
   always #50 core_clk = ~core_clk;
   tpa_remote_end u_tpa_remote_end (.core_clk(core_clk), .key(key), .guard_on(guard_on), .rx(rx1), .guard(g1));
   tpa_aux_logic #(.TICK_CYCLES(TK)) u_tpa_aux_logic (
      .core_clk(core_clk), .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
      .guard_in_one(g1), .guard_in_two(g2), .reverse_zone_pickup(rev), .forward_zone_pickup(fwd),
      .breaker_one_pos(bkr1), .breaker_two_pos(1'b1), .general_pickup_in(gpu),
      .permissive_rx_one(rx1), .permissive_rx_two(1'b0), .phase_volt(volt),
      .unblock_release(obs[0]), .unblock_trip(obs[1]), .chan_one_failed(obs[2]), .chan_two_failed(obs[9]),
      .reversal_block(obs[3]), .permissive_tx_out(obs[4]), .permissive_tx_ph_a(obs[6]),
      .permissive_tx_ph_b(obs[10]), .permissive_tx_ph_c(obs[11]), .echo_out(obs[5]),
      .weak_infeed_operated(obs[7]), .uv_pickup(obs[8]));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic summarize;
      $display("checks=%0d errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : summarize
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk) bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk) bus_req.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge core_clk) bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk) bus_req.rd <= 1'b0;
      #1 check(rd_data, exp);
   endtask : rd
   task automatic put_set(input int i, input int v);
      wr(OFS_SET0 + 8'(4 * i), 32'(v));
   endtask : put_set
   // Bounded wait; arriving before lo is as wrong as never arriving
   task automatic wait_obs(input int i, input logic v, input int lo, input int hi);
      int n = 0;
      // Step off the edge so an output launched there is seen settled
      #1;
      while (obs[i] !== v && n <= hi) begin
         @(posedge core_clk);
         #1 n++;
      end
      if (n > hi) begin
         num_errors++;
         summarize();
      end else begin
         check(32'(n >= lo), 32'h1);
      end
   endtask : wait_obs
   initial begin
      repeat (20) @(posedge core_clk);
      rst_b <= 1'b1;
      rd(OFS_SET0, 32'h0);
      rd(8'h3C, 32'h0);
      put_set(SI_GUARD_LOSS, 1);
      put_set(SI_WINDOW, 3);
      put_set(SI_CHAN_FAIL, 2);
      rd(OFS_SET0 + 8'(4 * SI_WINDOW), 32'h3);
      wr(OFS_CTRL, 32'h180);
      @(posedge core_clk) guard_on <= 1'b0;
      wait_obs(0, 1'b1, 0, 4 * TK);
      @(posedge core_clk) fwd <= 1'b1;
      wait_obs(1, 1'b1, 2, 4);
      wait_obs(0, 1'b0, 1, 5 * TK);
      wait_obs(2, 1'b1, 0, 4 * TK);
      check(obs[9], 1'b0);
      repeat (4 * TK) @(posedge core_clk);
      check(obs[0], 1'b0);
      @(posedge core_clk) fwd <= 1'b0;
      guard_on <= 1'b1;
      rev <= 1'b1;
      repeat (4 * TK) @(posedge core_clk);
      check(obs[3], 1'b0);
      rd(OFS_STATUS, 32'h0);
      put_set(SI_REV_CONF, 1);
      put_set(SI_REV_HOLD, 2);
      wr(OFS_CTRL, 32'h10);
      wait_obs(3, 1'b1, 0, 3 * TK);
      @(posedge core_clk) rev <= 1'b0;
      fwd <= 1'b1;
      wait_obs(3, 1'b0, TK, 4 * TK);
      put_set(SI_BKR_OPEN, 2);
      wr(OFS_CTRL, 32'h01);
      @(posedge core_clk) bkr1 <= 1'b0;
      fwd <= 1'b0;
      wait_obs(4, 1'b1, TK, 4 * TK);
      check({obs[11], obs[10], obs[6]}, 32'h0);
      put_set(SI_ECHO_PULSE, 3);
      put_set(SI_ECHO_LOCK, 5);
      wr(OFS_CTRL, 32'h24);
      @(posedge core_clk) key <= 1'b1;
      wait_obs(5, 1'b1, 3, 8);
      check({obs[11], obs[10], obs[6], obs[4]}, 32'hF);
      wait_obs(5, 1'b0, 2 * TK, 4 * TK + 2);
      wait_obs(5, 1'b1, 4 * TK, 7 * TK);
      // Closed breaker, supervised echo and weak infeed; let the last echo and lockout run out
      @(posedge core_clk) key <= 1'b0;
      bkr1 <= 1'b1;
      volt <= '{ph_a: 16'h8000, ph_b: 16'h8000, ph_c: 16'h8000};
      repeat (40) @(posedge core_clk);
      wr(OFS_UV_THR, 32'h8000);
      wr(OFS_UV_HYST, 32'h0100);
      put_set(SI_ECHO_CONF, 3);
      put_set(SI_PU_HOLD, 3);
      put_set(SI_WI_DELAY, 5);
      wr(OFS_CTRL, 32'h0E);
      // Half a unit over root three sits near 16'h49E6; reset level lies 16'h0100 above it
      @(posedge core_clk) volt.ph_a <= 16'h4A40;
      repeat (2) @(posedge core_clk);
      #1 check(obs[8], 1'b0);
      @(posedge core_clk) volt.ph_a <= 16'h49A0;
      repeat (2) @(posedge core_clk);
      #1 check(obs[8], 1'b1);
      @(posedge core_clk) volt.ph_a <= 16'h4A40;
      repeat (2) @(posedge core_clk);
      #1 check(obs[8], 1'b1);
      // Pickup lands while the echo confirm timer runs
      @(posedge core_clk) key <= 1'b1;
      repeat (8) @(posedge core_clk);
      gpu <= 1'b1;
      repeat (20) @(posedge core_clk);
      check({obs[7], obs[5]}, 32'h0);
      @(posedge core_clk) gpu <= 1'b0;
      wait_obs(5, 1'b1, 20, 30);
      wait_obs(7, 1'b1, 6, 10);
      @(posedge core_clk) gpu <= 1'b1;
      wait_obs(7, 1'b0, 2, 4);
      summarize();
   end
endmodule : teleprotection_aux_logic_tb
`default_nettype wire

// ==== verification/tpa_remote_end.sv ====
// Purpose: Remote line-end relay seen across the channel
// Assumes: Permission and guard are plain levels on the wire
// Notes:   Permission lags the key by LAT cycles, as a slow channel would
`timescale 1ns/1ps
`default_nettype none
module tpa_remote_end #(
   parameter int LAT = 3
) (
   input  wire logic core_clk,
   input  wire logic key,
   input  wire logic guard_on,
   output var logic  rx,
   output var logic  guard
);
   logic [LAT-1:0] dly_q = '0;
   always_ff @(posedge core_clk) begin
      dly_q <= {dly_q[LAT-2:0], key};
   end
   assign rx    = dly_q[LAT-1];
   assign guard = guard_on;
endmodule : tpa_remote_end
`default_nettype wire
